//--- verilog/serial_tx_pkg.sv
package serial_tx_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] baud_off = 8'h04;
  localparam logic [7:0] data_off = 8'h08;
  localparam logic [7:0] stat_off = 8'h0C;
  localparam logic [7:0] irq_sts_off = 8'h10;
  localparam logic [7:0] irq_mask_off = 8'h14;

  // Control register field positions.
  localparam int ctrl_transmit_enable_bit_pos = 0;
  localparam int ctrl_sync_pos = 1;
  localparam int ctrl_serial_port_enable_pos = 2;
  localparam int ctrl_nine_pos = 3;
  localparam int ctrl_pol_pos = 4;
  localparam int ctrl_ninth_pos = 5;
  localparam int ctrl_b16_pos = 6;
  localparam int ctrl_width = 7;

  // Status register field positions.
  localparam int stat_flag_pos = 0;
  localparam int stat_empty_pos = 1;
  localparam int stat_full_pos = 2;

  // Interrupt event positions, shared by status and mask.
  localparam int irq_done_pos = 0;
  localparam int irq_xfer_pos = 1;
  localparam int irq_width = 2;

  // Reset values.
  localparam logic [15:0] baud_reset = 16'h0067;
  localparam logic [31:0] read_zero = 32'h0000_0000;

  // Frame lengths in bits, start and stop included.
  localparam logic [3:0] frame_bits_8 = 4'hA;
  localparam logic [3:0] frame_bits_9 = 4'hB;

  // Control bits travel together as one packed word, bit 0 last.
  typedef struct packed {
    logic baud_16bit;
    logic ninth_transmit_bit;
    logic polarity_select;
    logic nine_bit_transmit_enable;
    logic serial_port_enable;
    logic mode_sync;
    logic transmit_enable_bit;
  } ctrl_s;

  typedef enum logic {tx_idle, tx_send} tx_state_e;

endpackage : serial_tx_pkg

//--- verilog/async_serial_transmitter.sv
// Operation
// [RULE_01] NRZ line, mark for one, idle mark.
// [RULE_02] Start space, 8/9 data, stop mark.
// [RULE_03] Each bit lasts one baud period.
// [RULE_04] Baud divider runs as 8 or 16 bits.
// [RULE_05] Data shifts out least significant bit first.
// [RULE_06] No parity bit; shared format and rate.
// [RULE_07] Shifter loads from holding buffer only, hidden.
// [RULE_08] Active only when enabled, asynchronous, port on.
// [RULE_09] Port enable turns on the output driver.
// [RULE_10] Pin direction handled by hardware, not software.
// [RULE_11] Flag set when enabled and buffer free.
// [RULE_12] Buffer write starts; idle shifter loads at once.
// [RULE_13] Busy shifter: hold until stop bit sent.
// [RULE_14] Frame starts right after the transfer.
// [RULE_15] Flag clears only busy with waiting character.
// [RULE_16] Read-only empty bit tracks shifter occupancy.
// [RULE_17] Nine-bit mode sends ninth bit as MSB.
// [RULE_18] Polarity select inverts idle and data levels.
// [RULE_19] Exactly one stop bit per character.
`timescale 1ns/1ns
`default_nettype none

module async_serial_transmitter #(
  parameter logic [15:0] baud_div_reset = serial_tx_pkg::baud_reset
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic transmit_output_pin,
  output logic transmit_output_oe,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  serial_tx_pkg::ctrl_s ctrl_q;
  serial_tx_pkg::tx_state_e state_q;
  logic [15:0] baud_q;
  logic [7:0] transmit_holding_buffer_q;
  logic hold_ninth_q;
  logic hold_full_q;
  logic [10:0] transmit_shift_register_q;
  logic [3:0] bits_left_q;
  logic [15:0] cnt_q;
  logic [serial_tx_pkg::irq_width-1:0] irq_sts_q;
  logic [serial_tx_pkg::irq_width-1:0] irq_mask_q;
  logic [serial_tx_pkg::irq_width-1:0] irq_ev;
  logic [31:0] rd_d;
  logic mapped;
  logic wr;
  logic active;
  logic line_raw;
  logic bit_end;
  logic frame_end;
  logic load;
  logic [15:0] reload;
  logic transmit_flag;
  logic shift_register_empty;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: writes take effect at the access edge, no wait states.
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;

  // All three enables must agree before anything is sent. see [RULE_08]
  assign active = ctrl_q.transmit_enable_bit && !ctrl_q.mode_sync && ctrl_q.serial_port_enable;

  // The divider is cut to its low byte in 8-bit mode. see [RULE_04]
  assign reload = ctrl_q.baud_16bit ? baud_q : {8'h00, baud_q[7:0]};

  assign bit_end = (state_q == serial_tx_pkg::tx_send) && (cnt_q == 16'h0000);
  // The last bit left is the single stop bit. see [RULE_19]
  assign frame_end = bit_end && (bits_left_q == 4'h1);

  // A waiting character moves in when the shifter is idle or its stop bit ends. see [RULE_12] see [RULE_13]
  assign load = active && hold_full_q && ((state_q == serial_tx_pkg::tx_idle) || frame_end);

  // Flag is high while active unless a character waits in the buffer. see [RULE_11] see [RULE_15]
  assign transmit_flag = active && !hold_full_q;
  assign shift_register_empty = (state_q == serial_tx_pkg::tx_idle); // see [RULE_16]

  ////////////////////////////////////////////////////////////////////////////
  // Control, baud and mask registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      baud_q <= baud_div_reset;
      irq_mask_q <= '0;
    end else if (wr) begin
      if (paddr == serial_tx_pkg::ctrl_off) begin
        ctrl_q <= pwdata[serial_tx_pkg::ctrl_width-1:0];
      end
      if (paddr == serial_tx_pkg::baud_off) begin
        baud_q <= pwdata[15:0];
      end
      if (paddr == serial_tx_pkg::irq_mask_off) begin
        irq_mask_q <= pwdata[serial_tx_pkg::irq_width-1:0];
      end
    end
  end

  // Holding buffer; the ninth bit is taken from control at the data write, so software sets it first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_holding_buffer_q <= 8'h00;
      hold_ninth_q <= 1'b0;
      hold_full_q <= 1'b0;
    end else if (!active) begin
      hold_full_q <= 1'b0;
    end else if (wr && (paddr == serial_tx_pkg::data_off)) begin
      transmit_holding_buffer_q <= pwdata[7:0];
      hold_ninth_q <= ctrl_q.ninth_transmit_bit; // see [RULE_17]
      hold_full_q <= 1'b1; // see [RULE_12]
    end else if (load) begin
      hold_full_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shifter and bit timer. The shifter has no bus path, so it cannot be read or written.
  // No parity is formed; the ninth bit is whatever software supplies. see [RULE_06] see [RULE_07]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= serial_tx_pkg::tx_idle;
      transmit_shift_register_q <= 11'h7FF;
      bits_left_q <= 4'h0;
      cnt_q <= 16'h0000;
    end else if (!active) begin
      state_q <= serial_tx_pkg::tx_idle;
      transmit_shift_register_q <= 11'h7FF;
    end else if (load) begin
      // Start bit goes out on the very next cycle. see [RULE_02] see [RULE_14]
      state_q <= serial_tx_pkg::tx_send;
      if (ctrl_q.nine_bit_transmit_enable) begin
        transmit_shift_register_q <= {1'b1, hold_ninth_q, transmit_holding_buffer_q, 1'b0}; // see [RULE_17]
        bits_left_q <= serial_tx_pkg::frame_bits_9;
      end else begin
        transmit_shift_register_q <= {2'b11, transmit_holding_buffer_q, 1'b0};
        bits_left_q <= serial_tx_pkg::frame_bits_8;
      end
      cnt_q <= reload;
    end else if (frame_end) begin
      state_q <= serial_tx_pkg::tx_idle;
      bits_left_q <= 4'h0;
    end else if (bit_end) begin
      // Shift right so the least significant bit leads. see [RULE_05]
      transmit_shift_register_q <= {1'b1, transmit_shift_register_q[10:1]};
      bits_left_q <= bits_left_q - 4'h1;
      cnt_q <= reload; // see [RULE_03]
    end else if (state_q == serial_tx_pkg::tx_send) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line drive: mark when idle, current bit while sending, optional inversion.
  assign line_raw = (state_q == serial_tx_pkg::tx_send) ? transmit_shift_register_q[0] : 1'b1; // see [RULE_01]

  // The pin is registered so it never glitches between bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_output_pin <= 1'b1;
      transmit_output_oe <= 1'b0;
    end else begin
      transmit_output_pin <= line_raw ^ ctrl_q.polarity_select; // see [RULE_18]
      // Driver follows the port enable; software never sets direction. see [RULE_09] see [RULE_10]
      transmit_output_oe <= ctrl_q.serial_port_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: a new event wins over a clear in the same cycle.
  assign irq_ev = {load, frame_end};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= '0;
    end else if (wr && (paddr == serial_tx_pkg::irq_sts_off)) begin
      irq_sts_q <= (irq_sts_q & ~pwdata[serial_tx_pkg::irq_width-1:0]) | irq_ev;
    end else begin
      irq_sts_q <= irq_sts_q | irq_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts_d_w() & irq_mask_q);
    end
  end

  // Next status value, so the level output has no extra cycle of lag.
  function automatic logic [serial_tx_pkg::irq_width-1:0] irq_sts_d_w();
    logic [serial_tx_pkg::irq_width-1:0] v;
    v = irq_sts_q | irq_ev;
    if (wr && (paddr == serial_tx_pkg::irq_sts_off)) begin
      v = (irq_sts_q & ~pwdata[serial_tx_pkg::irq_width-1:0]) | irq_ev;
    end
    return v;
  endfunction : irq_sts_d_w

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; captured in the setup cycle so prdata comes from a flip-flop.
  always_comb begin
    rd_d = serial_tx_pkg::read_zero;
    mapped = 1'b1;
    case (paddr)
      serial_tx_pkg::ctrl_off: rd_d[serial_tx_pkg::ctrl_width-1:0] = ctrl_q;
      serial_tx_pkg::baud_off: rd_d[15:0] = baud_q;
      serial_tx_pkg::data_off: rd_d = serial_tx_pkg::read_zero;
      serial_tx_pkg::stat_off: begin
        rd_d[serial_tx_pkg::stat_flag_pos] = transmit_flag;
        rd_d[serial_tx_pkg::stat_empty_pos] = shift_register_empty;
        rd_d[serial_tx_pkg::stat_full_pos] = hold_full_q;
      end
      serial_tx_pkg::irq_sts_off: rd_d[serial_tx_pkg::irq_width-1:0] = irq_sts_q;
      serial_tx_pkg::irq_mask_off: rd_d[serial_tx_pkg::irq_width-1:0] = irq_mask_q;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= serial_tx_pkg::read_zero;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? serial_tx_pkg::read_zero : rd_d;
      pslverr <= !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Checked at the pin, so the output register and the inversion are covered too.
  property p_idle_mark;
    @(posedge pclk) disable iff (!presetn)
      (state_q == serial_tx_pkg::tx_idle) |=> (transmit_output_pin != $past(ctrl_q.polarity_select));
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("Line not at mark while idle."); // see [RULE_01]

  property p_start_space;
    @(posedge pclk) disable iff (!presetn)
      load |=> (!line_raw && (state_q == serial_tx_pkg::tx_send));
  endproperty
  a_start_space: assert property (p_start_space) else $error("Start bit missing after load."); // see [RULE_02]

  property p_bit_hold;
    @(posedge pclk) disable iff (!presetn)
      (active && (state_q == serial_tx_pkg::tx_send) && (cnt_q != 16'h0000)) |=> $stable(line_raw);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("Line changed inside a bit."); // see [RULE_03]

  property p_baud_8bit;
    @(posedge pclk) disable iff (!presetn)
      (!ctrl_q.baud_16bit && (load || bit_end)) |=> (cnt_q[15:8] == 8'h00);
  endproperty
  a_baud_8bit: assert property (p_baud_8bit) else $error("Upper divider byte used in 8-bit mode."); // see [RULE_04]

  property p_lsb_first;
    @(posedge pclk) disable iff (!presetn)
      (active && bit_end && !frame_end && !load) |=> (line_raw == $past(transmit_shift_register_q[1]));
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("Bits not shifted low first."); // see [RULE_05]

  property p_driver;
    @(posedge pclk) disable iff (!presetn)
      ##1 (transmit_output_oe == $past(ctrl_q.serial_port_enable));
  endproperty
  a_driver: assert property (p_driver) else $error("Output driver does not follow port enable."); // see [RULE_09]

  property p_flag;
    @(posedge pclk) disable iff (!presetn)
      (wr && (paddr == serial_tx_pkg::data_off) && active && !ctrl_q.mode_sync)
        |=> (!transmit_flag || (state_q == serial_tx_pkg::tx_send)) ##1 (transmit_flag || !shift_register_empty);
  endproperty
  a_flag: assert property (p_flag) else $error("Transmit flag wrong after buffer write."); // see [RULE_15]

  property p_immediate;
    @(posedge pclk) disable iff (!presetn)
      (wr && (paddr == serial_tx_pkg::data_off) && active && shift_register_empty)
        |=> ##1 (state_q == serial_tx_pkg::tx_send || !active);
  endproperty
  a_immediate: assert property (p_immediate) else $error("Idle shifter did not take new character."); // see [RULE_12]

  property p_pending;
    @(posedge pclk) disable iff (!presetn)
      (frame_end && hold_full_q && active) |=> ((state_q == serial_tx_pkg::tx_send) && !line_raw);
  endproperty
  a_pending: assert property (p_pending) else $error("Queued character not moved after stop bit."); // see [RULE_13]

  property p_stop_mark;
    @(posedge pclk) disable iff (!presetn)
      ((state_q == serial_tx_pkg::tx_send) && (bits_left_q == 4'h1)) |-> line_raw;
  endproperty
  a_stop_mark: assert property (p_stop_mark) else $error("Stop bit not at mark."); // see [RULE_19]

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
      ##1 (transmit_output_pin == ($past(line_raw) ^ $past(ctrl_q.polarity_select)));
  endproperty
  a_polarity: assert property (p_polarity) else $error("Pin polarity wrong."); // see [RULE_18]

  // Any of the three enables dropping must leave the shifter idle and the buffer empty.
  property p_inactive;
    @(posedge pclk) disable iff (!presetn)
      !active |=> ((state_q == serial_tx_pkg::tx_idle) && !hold_full_q);
  endproperty
  a_inactive: assert property (p_inactive) else $error("Transmitter ran while disabled."); // see [RULE_08]

  // Outside the settling cycle after a buffer write, a low flag means busy with a waiting character.
  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
      (active && !transmit_flag && !$past(wr && (paddr == serial_tx_pkg::data_off)))
        |-> (hold_full_q && (state_q == serial_tx_pkg::tx_send));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Transmit flag low without a queued character."); // see [RULE_15]

  // The empty bit stays clear until the stop bit has gone.
  property p_empty_hold;
    @(posedge pclk) disable iff (!presetn)
      (active && !shift_register_empty && (bits_left_q != 4'h1)) |=> !shift_register_empty;
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("Empty bit set before frame end."); // see [RULE_16]

  // Nine-bit frames are one bit longer and carry the latched ninth bit above the data byte.
  property p_nine;
    @(posedge pclk) disable iff (!presetn)
      (load && ctrl_q.nine_bit_transmit_enable)
        |=> ((bits_left_q == serial_tx_pkg::frame_bits_9) && (transmit_shift_register_q[9] == $past(hold_ninth_q)));
  endproperty
  a_nine: assert property (p_nine) else $error("Ninth bit not framed as most significant bit."); // see [RULE_17]

  c_nine_bit: cover property (@(posedge pclk) disable iff (!presetn) load && ctrl_q.nine_bit_transmit_enable);
  c_back_to_back: cover property (@(posedge pclk) disable iff (!presetn) frame_end && load);
  c_inverted: cover property (@(posedge pclk) disable iff (!presetn) frame_end && ctrl_q.polarity_select);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
  c_sixteen: cover property (@(posedge pclk) disable iff (!presetn) load && ctrl_q.baud_16bit);

endmodule : async_serial_transmitter

`default_nettype wire

//--- testbench/serial_rx_model.sv
`timescale 1ns/1ns
`default_nettype none

module serial_rx_model (
  input wire logic pclk,
  input wire logic line,
  input wire logic pol,
  input wire logic nine,
  input wire logic [16:0] bit_cycles,
  output logic [8:0] rx_data,
  output logic rx_err,
  output int rx_count
);
  logic [8:0] sh;

  ////////////////////////////////////////////////////////////////////////////
  // Samples mid-bit on the falling edge, well clear of the line's launch edge.
  // A start that is gone at mid-bit is dropped quietly, as a real receiver does.
  initial begin
    rx_data = 9'h000;
    rx_err = 1'b0;
    rx_count = 0;
    forever begin
      @(negedge pclk);
      if ((line ^ pol) === 1'b0) begin
        repeat (bit_cycles / 2) @(negedge pclk);
        if ((line ^ pol) === 1'b0) begin
          sh = 9'h000;
          for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bit_cycles) @(negedge pclk);
            sh[i] = line ^ pol;
          end
          repeat (bit_cycles) @(negedge pclk);
          if ((line ^ pol) !== 1'b1) rx_err = 1'b1;
          rx_data = sh;
          rx_count++;
        end
      end
    end
  end
endmodule : serial_rx_model

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  localparam logic [7:0] ctrl_a = serial_tx_pkg::ctrl_off;
  localparam logic [7:0] data_a = serial_tx_pkg::data_off;
  localparam logic [7:0] stat_a = serial_tx_pkg::stat_off;
  localparam logic [7:0] sts_a = serial_tx_pkg::irq_sts_off;
  localparam logic [7:0] msk_a = serial_tx_pkg::irq_mask_off;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line, line_oe, irq, pol, nine, rx_err, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [16:0] bit_cycles;
  logic [8:0] rx_data;
  int rx_count;
  int failures;
  int compares;

  async_serial_transmitter u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmit_output_pin(line), .transmit_output_oe(line_oe), .irq(irq)
  );

  serial_rx_model u_rx (
    .pclk(pclk), .line(line), .pol(pol), .nine(nine), .bit_cycles(bit_cycles),
    .rx_data(rx_data), .rx_err(rx_err), .rx_count(rx_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared checking, bus and verdict tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; the leading edge keeps two transfers from touching psel in one step.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the watchdog ends a hung transfer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  // Waits for the n-th character, then lets its stop bit finish.
  task automatic wait_rx(input int n);
    // No local limit: a character that never arrives is left to the watchdog.
    while (rx_count < n) begin
      @(posedge pclk);
    end
    repeat (bit_cycles) @(posedge pclk);
  endtask : wait_rx

  task automatic stop_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Watchdog; the whole run needs well under a quarter of this.
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {psel, penable, pwrite, presetn, pol, nine} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    bit_cycles = 17'h00004;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Look between edges, away from the edge that releases reset.
    @(negedge pclk);
    chk({29'h0, pready, line_oe, line}, 32'h5);
    rd(serial_tx_pkg::baud_off, {16'h0, serial_tx_pkg::baud_reset});
    rd(stat_a, 32'h2);
    rd(8'h18, 32'h0);
    chk(32'(err), 32'h1);
    // Enable with a divider whose upper byte must be ignored in 8-bit mode.
    wr(serial_tx_pkg::baud_off, 32'h0103);
    wr(ctrl_a, 32'h05);
    rd(stat_a, 32'h3);
    chk(32'(line_oe), 32'h1);
    wr(data_a, 32'hA5);
    repeat (2) @(negedge pclk);
    chk(32'(line), 32'h1);
    @(negedge pclk);
    chk(32'(line), 32'h0);
    repeat (3) @(negedge pclk);
    chk(32'(line), 32'h0);
    @(negedge pclk);
    chk(32'(line), 32'h1);
    // Queue a second character while the shifter is busy.
    wr(data_a, 32'h3C);
    rd(stat_a, 32'h4);
    rd(data_a, 32'h0);
    wait_rx(1);
    chk({23'h0, rx_data}, 32'hA5);
    wait_rx(2);
    chk({23'h0, rx_data}, 32'h3C);
    rd(stat_a, 32'h3);
    // Sixteen-bit divider: 0x0103 gives 260 cycles a bit.
    bit_cycles = 17'h00104;
    wr(ctrl_a, 32'h45);
    wr(data_a, 32'h81);
    wait_rx(3);
    chk({23'h0, rx_data}, 32'h81);
    bit_cycles = 17'h00004;
    nine = 1'b1;
    wr(ctrl_a, 32'h2D);
    wr(data_a, 32'h3C);
    wait_rx(4);
    chk({23'h0, rx_data}, 32'h13C);
    nine = 1'b0;
    wr(ctrl_a, 32'h15);
    pol = 1'b1;
    repeat (2) @(negedge pclk);
    chk(32'(line), 32'h0);
    wr(data_a, 32'h0F);
    wait_rx(5);
    chk({23'h0, rx_data}, 32'h0F);
    // Synchronous mode selected: a data write must not send anything.
    wr(ctrl_a, 32'h07);
    pol = 1'b0;
    rd(stat_a, 32'h2);
    wr(data_a, 32'h55);
    repeat (60) @(posedge pclk);
    chk({line, 31'(rx_count)}, 32'h8000_0005);
    chk(32'(rx_err), 32'h0);
    // Interrupts: both events pending, mask one, clear it by writing one.
    rd(sts_a, 32'h3);
    chk(32'(irq), 32'h0);
    wr(msk_a, 32'h1);
    rd(msk_a, 32'h1);
    chk(32'(irq), 32'h1);
    wr(sts_a, 32'h1);
    rd(sts_a, 32'h2);
    chk(32'(irq), 32'h0);
    stop_test();
  end
endmodule : testbench

`default_nettype wire
